/* File: src/rsp_pkg.sv */
package rsp_pkg;
  // Prescaler width and watchdog-service clear field
  localparam int PRESC_W = 13;
  localparam int PRESC_CLR_LO = 4;
  localparam int PRESC_CLR_HI = 12;
  // Sequencer cycle counts in osc_ref_clock cycles; the low-voltage filter count is in CPU cycles
  localparam logic [12:0] STAB_CYCLES = 13'h1000;
  localparam logic [12:0] DRIVE_CYCLES = 13'h0020;
  localparam logic [12:0] HOLD_CYCLES = 13'h0020;
  localparam logic [12:0] RELEASE_CYCLES = 13'h0040;
  localparam logic [12:0] PIN_MIN_CYCLES = 13'h0043;
  localparam logic [12:0] PIN_MIN_PWR_CYCLES = 13'h1043;
  localparam logic [3:0] LV_FILTER_CYCLES = 4'h9;
  // Reset vector addresses
  localparam logic [15:0] VEC_USER = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFE;
  // Cause flag positions in reset_cause_register
  localparam int CAUSE_POR = 7;
  localparam int CAUSE_PIN = 6;
  localparam int CAUSE_WDOG = 5;
  localparam int CAUSE_BADOP = 4;
  localparam int CAUSE_BADADDR = 3;
  localparam int CAUSE_LV = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    RSP_RUN = 3'b000,
    RSP_STAB = 3'b001,
    RSP_DRIVE = 3'b011,
    RSP_HOLD = 3'b010,
    RSP_PINLOW = 3'b110
  } rsp_state_e;
endpackage : rsp_pkg

/* File: src/rsp_lv_filter.sv */
`timescale 1ns/1ps
// Passes a low-voltage request only after nine consecutive low samples
module rsp_lv_filter
  import rsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpuCycle,
  input wire logic belowTrip,
  output logic lvRequest
);
  logic [3:0] run;
  logic [3:0] next_run;
  logic next_lvRequest;

  // Count consecutive CPU cycles at or below trip_threshold
  always_comb
  begin
    next_run = run;
    next_lvRequest = lvRequest;
    if (!belowTrip)
    begin
      next_run = 4'h0;
      next_lvRequest = 1'b0;
    end
    else if (cpuCycle)
    begin
      if (run < LV_FILTER_CYCLES)
        next_run = run + 4'h1;
      if (run + 4'h1 >= LV_FILTER_CYCLES)
        next_lvRequest = 1'b1; // [R20]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run <= 4'h0;
      lvRequest <= 1'b0;
    end
    else
    begin
      run <= next_run;
      lvRequest <= next_lvRequest;
    end
  end

  lv_late_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lvRequest) |-> $past(belowTrip)) else $error("lv request without low supply"); // [R20]
endmodule : rsp_lv_filter

/* File: src/rsp_sequencer.sv */
`timescale 1ns/1ps
// Function
// R1 - Every reset source asserts internal reset; vector FFFE, FEFE in monitor mode.
// R2 - Internal reset returns every register and module to its reset state.
// R3 - Internal reset clears prescaler; pin-only reset leaves it alone.
// R4 - Each reset source sets its own cause flag.
// R5 - Pin low halts processing immediately, without waiting for a clock; code registers haltProcessing, so it follows one clock later.
// R6 - Pin flag needs 67 low cycles, 4163 after power-on or low voltage.
// R7 - Internal sources drive pin low 32 cycles, then hold reset 32 more.
// R8 - Power-on and low voltage first count 4096 cycles with pin low.
// R9 - Watchdog request is accepted independent of the bus clock.
// R10 - After stabilization wait 64 cycles, then release CPU and memories.
// R11 - At power-on enable core clock, hold CPU clocks 4096 cycles.
// R12 - Power-on sets its flag and clears all other cause flags.
// R13 - Watchdog overflow triggers internal reset and sets its flag.
// R14 - Write to top vector byte clears watchdog and prescaler bits 12..4.
// R15 - Prescaler output to watchdog occurs at least every 2^13-2^4 cycles.
// R16 - Watchdog disable only via high-voltage detect in monitor or break.
// R17 - Illegal opcode, including low-power halt, sets its flag and resets.
// R18 - Fetch outside program memory or RAM sets its flag and resets.
// R19 - Data access to unmapped address never resets.
// R20 - Low-voltage request only after nine consecutive low CPU cycles.
// R21 - Low-voltage reset sets its flag, uses power-on timing.
// R22 - Prescaler is 13 bits, advancing each osc_ref_clock falling edge; code advances it on the rising edge of clk.
// R23 - Prescaler runs freely once reset states have ended.
// R24 - Reading reset_cause_register clears all cause flags.
// R25 - Pin level is synchronized before its low duration is counted.
module rsp_sequencer
  import rsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powerOnPulse,
  input wire logic extResetIn,
  input wire logic watchdogOverflow,
  input wire logic cpuCycle,
  input wire logic belowTrip,
  input wire logic badOpcode,
  input wire logic lowPowerHaltOpcode,
  input wire logic opcodeFetch,
  input wire logic fetchInMemory,
  input wire logic monitorMode,
  input wire logic breakState,
  input wire logic resetPinHighVolt,
  input wire logic irqPinHighVolt,
  input wire logic topVectorWrite,
  input wire logic causeRead,
  output logic extResetOut,
  output logic extResetOe,
  output logic internalReset,
  output logic haltProcessing,
  output logic coreSourceClockEn,
  output logic internalBusClocksEn,
  output logic [15:0] resetVector,
  output logic [7:0] resetCause,
  output logic [12:0] prescaler,
  output logic watchdogTick,
  output logic watchdogClear,
  output logic watchdogDisable
);
  rsp_state_e state;
  rsp_state_e next_state;
  logic [12:0] count;
  logic [12:0] next_count;
  logic pinSync1;
  logic pinSync2;
  logic [12:0] pinLow;
  logic [12:0] next_pinLow;
  logic pwrSeq;
  logic next_pwrSeq;
  logic [7:0] next_resetCause;
  logic [12:0] next_prescaler;
  logic lvRequest;
  logic intSrc;
  logic pwrSrc;
  logic next_internalReset;
  logic next_extResetOe;
  logic next_clocksEn;
  logic next_tick;
  logic next_clear;
  logic next_disable;
  logic next_halt;
  logic [15:0] next_vector;

  // Filtered low-voltage request
  rsp_lv_filter lvFilter (
    .clk(clk),
    .rst_n(rst_n),
    .cpuCycle(cpuCycle),
    .belowTrip(belowTrip),
    .lvRequest(lvRequest)
  );

  // Internal reset sources; data accesses never appear here
  assign pwrSrc = powerOnPulse | lvRequest;
  assign intSrc = pwrSrc | watchdogOverflow | badOpcode | lowPowerHaltOpcode
    | (opcodeFetch & ~fetchInMemory); // [R13] [R17] [R18] [R19]

  // Pin synchronizer, second stage feeds the low-time counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
    end
    else
    begin
      pinSync1 <= extResetIn;
      pinSync2 <= pinSync1; // [R25]
    end
  end

  // Sequencer: stabilization, pin drive, reset hold
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_pwrSeq = pwrSeq;
    unique case (state)
      RSP_RUN:
      begin
        if (pwrSrc)
        begin
          next_state = RSP_STAB; // [R8] [R21]
          next_count = 13'h0000;
          next_pwrSeq = 1'b1;
        end
        else if (intSrc)
        begin
          next_state = RSP_DRIVE; // [R7] [R9]
          next_count = 13'h0000;
          next_pwrSeq = 1'b0;
        end
        else if (!pinSync2)
        begin
          next_state = RSP_PINLOW;
          next_pwrSeq = 1'b0;
        end
      end
      RSP_STAB:
      begin
        next_count = count + 13'h0001;
        if (count == STAB_CYCLES - 13'h0001)
        begin
          next_state = RSP_DRIVE; // [R10] [R11]
          next_count = 13'h0000;
        end
      end
      RSP_DRIVE:
      begin
        next_count = count + 13'h0001;
        if (count == DRIVE_CYCLES - 13'h0001)
        begin
          next_state = RSP_HOLD;
          next_count = 13'h0000;
        end
      end
      RSP_HOLD:
      begin
        next_count = count + 13'h0001;
        if (count == HOLD_CYCLES - 13'h0001)
          next_state = pinSync2 ? RSP_RUN : RSP_PINLOW; // [R7]
      end
      RSP_PINLOW:
      begin
        if (pwrSrc)
        begin
          next_state = RSP_STAB;
          next_count = 13'h0000;
          next_pwrSeq = 1'b1;
        end
        else if (intSrc)
        begin
          next_state = RSP_DRIVE;
          next_count = 13'h0000;
        end
        else if (pinSync2)
          next_state = RSP_RUN;
      end
      default:
        next_state = RSP_RUN;
    endcase
    if (powerOnPulse && state != RSP_STAB)
    begin
      next_state = RSP_STAB;
      next_count = 13'h0000;
      next_pwrSeq = 1'b1;
    end
  end

  // Outputs derived from the next state, the mode and pin inputs and the service write, all registered
  always_comb
  begin
    next_internalReset = next_state != RSP_RUN; // [R1] [R2]
    next_extResetOe = next_state == RSP_STAB || next_state == RSP_DRIVE; // [R7] [R8]
    next_clocksEn = next_state != RSP_STAB; // [R11]
    next_vector = monitorMode ? VEC_MONITOR : VEC_USER; // [R1]
    next_halt = next_internalReset | ~extResetIn; // [R5]
    next_disable = (monitorMode & (resetPinHighVolt | irqPinHighVolt))
      | (breakState & resetPinHighVolt); // [R16]
    next_clear = topVectorWrite; // [R14]
  end

  // Pin low-time count, restarted whenever the pin is high
  always_comb
  begin
    next_pinLow = pinSync2 ? 13'h0000 : pinLow;
    if (!pinSync2 && pinLow != PIN_MIN_PWR_CYCLES)
      next_pinLow = pinLow + 13'h0001;
  end

  // Cause flags: set wins over read-clear, power-on clears the rest
  always_comb
  begin
    next_resetCause = causeRead ? 8'h00 : resetCause; // [R24]
    if (powerOnPulse)
      next_resetCause = CAUSE_RESET; // [R12]
    else
    begin
      if (lvRequest)
        next_resetCause[CAUSE_LV] = 1'b1; // [R4] [R21]
      if (watchdogOverflow)
        next_resetCause[CAUSE_WDOG] = 1'b1; // [R13]
      if (badOpcode || lowPowerHaltOpcode)
        next_resetCause[CAUSE_BADOP] = 1'b1; // [R17]
      if (opcodeFetch && !fetchInMemory)
        next_resetCause[CAUSE_BADADDR] = 1'b1; // [R18]
      if (!pinSync2 && next_pinLow == (pwrSeq ? PIN_MIN_PWR_CYCLES : PIN_MIN_CYCLES))
        next_resetCause[CAUSE_PIN] = 1'b1; // [R6]
    end
  end

  // Prescaler: cleared by internal reset other than pin-only reset, partly by service write
  always_comb
  begin
    next_prescaler = prescaler + 13'h0001; // [R22] [R23]
    if (next_internalReset && state != RSP_PINLOW && next_state != RSP_PINLOW)
      next_prescaler = 13'h0000; // [R3]
    else if (topVectorWrite)
      next_prescaler[PRESC_CLR_HI:PRESC_CLR_LO] = '0; // [R14]
    next_tick = prescaler == {PRESC_W{1'b1}} && next_prescaler == 13'h0000; // [R15]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= RSP_STAB;
      count <= 13'h0000;
      pwrSeq <= 1'b1;
      pinLow <= 13'h0000;
      resetCause <= CAUSE_RESET;
      prescaler <= 13'h0000;
      internalReset <= 1'b1;
      extResetOe <= 1'b1;
      extResetOut <= 1'b0;
      haltProcessing <= 1'b1;
      coreSourceClockEn <= 1'b0;
      internalBusClocksEn <= 1'b0;
      resetVector <= VEC_USER;
      watchdogTick <= 1'b0;
      watchdogClear <= 1'b0;
      watchdogDisable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      pwrSeq <= next_pwrSeq;
      pinLow <= next_pinLow;
      resetCause <= next_resetCause;
      prescaler <= next_prescaler;
      internalReset <= next_internalReset;
      extResetOe <= next_extResetOe;
      extResetOut <= 1'b0;
      haltProcessing <= next_halt;
      coreSourceClockEn <= 1'b1; // [R11]
      internalBusClocksEn <= next_clocksEn;
      resetVector <= next_vector;
      watchdogTick <= next_tick;
      watchdogClear <= next_clear;
      watchdogDisable <= next_disable;
    end
  end

  stab_length_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state == RSP_STAB) |-> (state == RSP_STAB) [*8]) else $error("stab too short"); // [R8]
  drive_to_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state == RSP_DRIVE && count == DRIVE_CYCLES - 13'h0001) |=> state == RSP_HOLD) else $error("drive end"); // [R7]
  clk_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == RSP_STAB |-> !internalBusClocksEn) else $error("bus clocks during stabilization"); // [R11]
  por_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    powerOnPulse |=> resetCause == CAUSE_RESET) else $error("power-on flags wrong"); // [R12]
  wdog_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    watchdogOverflow && !powerOnPulse |=> resetCause[CAUSE_WDOG] && internalReset) else $error("watchdog flag"); // [R13]
  fetch_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    opcodeFetch && !fetchInMemory |=> internalReset) else $error("bad fetch no reset"); // [R18]
  presc_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    topVectorWrite && !next_internalReset |=> prescaler[PRESC_CLR_HI:PRESC_CLR_LO] == '0)
    else $error("service clear"); // [R14]
  pin_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    state == RSP_PINLOW && next_state == RSP_PINLOW && !topVectorWrite
    |=> prescaler == $past(prescaler) + 13'h0001)
    else $error("pin reset touched prescaler"); // [R3]
  halt_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    !extResetIn |=> haltProcessing) else $error("no halt on pin"); // [R5]
  cause_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    causeRead && !intSrc && pinSync2 |=> resetCause == 8'h00) else $error("read clear"); // [R24]

  por_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(internalReset));
  wdog_seen_c: cover property (@(posedge clk) disable iff (!rst_n) watchdogOverflow && state == RSP_RUN);
  pin_flag_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(resetCause[CAUSE_PIN]));
endmodule : rsp_sequencer

/* File: dv/rsp_reset_peer.sv */
`timescale 1ns/1ps
// Peripheral sharing the open-drain reset line, with the line's pull-up
module rsp_reset_peer
(
  input wire logic clk,
  input wire logic start,
  input wire logic [12:0] holdLen,
  input wire logic extResetOe,
  input wire logic extResetOut,
  output logic pinLevel
);
  logic [12:0] cnt = 13'h0000;
  // Holds the line low for the requested number of cycles
  always @(posedge clk)
  begin
    if (start)
      cnt <= holdLen;
    else if (cnt != 13'h0000)
      cnt <= cnt - 13'h0001;
  end
  // Wired low from either party; a released line is pulled high
  assign pinLevel = !((cnt != 13'h0000) || (extResetOe && !extResetOut));
endmodule : rsp_reset_peer

/* File: dv/reset_sequencer_and_prescaler_test.sv */
`timescale 1ns/1ps
module reset_sequencer_and_prescaler_test;
  import rsp_pkg::*;
  logic clk, rst_n, powerOnPulse, watchdogOverflow, cpuCycle, belowTrip, badOpcode;
  logic lowPowerHaltOpcode, opcodeFetch, fetchInMemory, monitorMode, breakState;
  logic resetPinHighVolt, irqPinHighVolt, topVectorWrite, causeRead, start, skip;
  logic extResetIn, extResetOut, extResetOe, internalReset, haltProcessing;
  logic coreSourceClockEn, internalBusClocksEn, watchdogTick, watchdogClear, watchdogDisable;
  logic [15:0] resetVector, irW, oeW;
  logic [12:0] prescaler, holdLen, q;
  logic [7:0] resetCause;
  logic [39:0] expQ[$];
  logic [39:0] e;
  logic [4:0] combos [5] = '{5'b10101, 5'b10011, 5'b00110, 5'b01101, 5'b01010};
  int miscompares = 0;
  int samplesChecked = 0;
  int cyc = 0;
  int n;

  rsp_sequencer u_dut (.clk(clk), .rst_n(rst_n), .powerOnPulse(powerOnPulse),
    .extResetIn(extResetIn), .watchdogOverflow(watchdogOverflow), .cpuCycle(cpuCycle),
    .belowTrip(belowTrip), .badOpcode(badOpcode), .lowPowerHaltOpcode(lowPowerHaltOpcode),
    .opcodeFetch(opcodeFetch), .fetchInMemory(fetchInMemory), .monitorMode(monitorMode),
    .breakState(breakState), .resetPinHighVolt(resetPinHighVolt),
    .irqPinHighVolt(irqPinHighVolt), .topVectorWrite(topVectorWrite), .causeRead(causeRead),
    .extResetOut(extResetOut), .extResetOe(extResetOe), .internalReset(internalReset),
    .haltProcessing(haltProcessing), .coreSourceClockEn(coreSourceClockEn),
    .internalBusClocksEn(internalBusClocksEn), .resetVector(resetVector),
    .resetCause(resetCause), .prescaler(prescaler), .watchdogTick(watchdogTick),
    .watchdogClear(watchdogClear), .watchdogDisable(watchdogDisable));
  rsp_reset_peer u_peer (.clk(clk), .start(start), .holdLen(holdLen),
    .extResetOe(extResetOe), .extResetOut(extResetOut), .pinLevel(extResetIn));

  // Free-running 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts one comparison and reports a mismatch
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samplesChecked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  // Prints the counts and the verdict, then stops
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Waits, bounded, until the reset sequence has released
  task automatic waitIdle();
    n = 0;
    do @(negedge clk) n++; while (internalReset !== 1'b0 && n < 5000);
    check(internalReset, 16'h0000, "reset never released");
    repeat (3) @(posedge clk);
  endtask : waitIdle

  // Reads the cause flags, which empties them
  task automatic clearCause();
    @(posedge clk) causeRead <= 1'b1;
    @(posedge clk) causeRead <= 1'b0;
    @(negedge clk) check(resetCause, 16'h0000, "cause not cleared by read");
  endtask : clearCause

  // One-cycle request from an internal reset source
  task automatic fire(input int i);
    @(posedge clk);
    case (i)
      0: watchdogOverflow <= 1'b1;
      1: badOpcode <= 1'b1;
      2: lowPowerHaltOpcode <= 1'b1;
      default:
      begin
        opcodeFetch <= 1'b1;
        fetchInMemory <= 1'b0;
      end
    endcase
    @(posedge clk);
    {watchdogOverflow, badOpcode, lowPowerHaltOpcode, opcodeFetch} <= 4'h0;
    fetchInMemory <= 1'b1;
  endtask : fire

  // Asks the peripheral to hold the reset line low
  task automatic pinHold(input logic [12:0] len);
    @(posedge clk);
    start <= 1'b1;
    holdLen <= len;
    @(posedge clk) start <= 1'b0;
  endtask : pinHold

  // Cuts a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // Measures each reset pulse and compares it with the oldest note
  always @(negedge clk)
  begin
    if (!rst_n)
    begin
      skip = 1'b1;
      irW = 16'h0000;
      oeW = 16'h0000;
    end
    else if (internalReset)
    begin
      if (irW == 16'h0000 && !skip && expQ.size() > 0)
        check(prescaler, 16'h0000, "prescaler not cleared");
      irW++;
      if (extResetOe)
        oeW++;
    end
    else
    begin
      if (irW != 16'h0000 && !skip && expQ.size() > 0)
      begin
        e = expQ.pop_front();
        check(irW, e[39:24], "internal reset length");
        check(oeW, e[23:8], "pin drive length");
        check(resetCause, e[7:0], "cause flags");
      end
      irW = 16'h0000;
      oeW = 16'h0000;
      skip = 1'b0;
    end
  end

  // Main sequence
  initial
  begin
    {powerOnPulse, watchdogOverflow, cpuCycle, belowTrip, badOpcode} = 5'h00;
    {lowPowerHaltOpcode, opcodeFetch, monitorMode, breakState} = 4'h0;
    {resetPinHighVolt, irqPinHighVolt, topVectorWrite, causeRead, start} = 5'h00;
    fetchInMemory = 1'b1;
    holdLen = 13'h0000;
    rst_n = 1'b0;
    void'($urandom(34512));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (50) @(negedge clk);
    check(internalBusClocksEn, 16'h0000, "bus clocks on in stab");
    check(coreSourceClockEn, 16'h0001, "core clock off");
    check(extResetOe, 16'h0001, "pin not driven in stab");
    check(resetCause, 16'h0080, "power-on cause");
    check(resetVector, 16'hFFFE, "user vector");
    waitIdle();
    // Supply dip: eight low CPU cycles pass, the ninth resets
    clearCause();
    @(posedge clk) belowTrip <= 1'b1;
    for (int k = 1; k <= 9; k++)
    begin
      if (k == 9)
        expQ.push_back({16'h1040, 16'h1020, 8'h02});
      repeat ($urandom_range(1, 3)) @(posedge clk);
      cpuCycle <= 1'b1;
      @(posedge clk) cpuCycle <= 1'b0;
      if (k == 8)
      begin
        repeat (3) @(negedge clk);
        check(internalReset, 16'h0000, "early low-voltage reset");
      end
    end
    repeat (10) @(negedge clk);
    check(internalBusClocksEn, 16'h0000, "bus clocks on after dip");
    @(posedge clk) belowTrip <= 1'b0;
    waitIdle();
    // Each internal source in turn
    for (int i = 0; i < 4; i++)
    begin
      clearCause();
      expQ.push_back({16'h0040, 16'h0020, (i == 0) ? 8'h20 : (i == 3) ? 8'h08 : 8'h10});
      fire(i);
      waitIdle();
    end
    // Data access to an unmapped place
    @(posedge clk) fetchInMemory <= 1'b0;
    repeat (20) @(negedge clk);
    check(internalReset, 16'h0000, "data access reset");
    @(posedge clk) fetchInMemory <= 1'b1;
    // Short and long pin pulses from the peripheral
    clearCause();
    pinHold(13'($urandom_range(12, 60)));
    repeat (4) @(negedge clk);
    check(haltProcessing, 16'h0001, "no halt on pin low");
    q = prescaler;
    repeat (4) @(negedge clk);
    check(prescaler, 16'(q + 13'h0004), "prescaler disturbed by pin");
    repeat (100) @(negedge clk);
    check(resetCause, 16'h0000, "short pin pulse flagged");
    waitIdle();
    pinHold(13'h005A);
    repeat (200) @(negedge clk);
    check(resetCause, 16'h0040, "pin cause");
    waitIdle();
    // Service write clears the upper prescaler field only
    n = 0;
    do @(negedge clk) n++; while (prescaler[3:0] !== 4'h2 && n < 40);
    @(posedge clk) topVectorWrite <= 1'b1;
    @(posedge clk) topVectorWrite <= 1'b0;
    @(negedge clk) check(prescaler, 16'h0004, "service clear");
    n = 0;
    do @(negedge clk) n++; while (watchdogTick !== 1'b1 && n < 8192);
    check(watchdogTick, 16'h0001, "no watchdog tick");
    // Power-on pulse in mid-run; its flag replaces the pin flag left above
    expQ.push_back({16'h1040, 16'h1020, 8'h80});
    @(posedge clk) powerOnPulse <= 1'b1;
    @(posedge clk) powerOnPulse <= 1'b0;
    waitIdle();
    // Watchdog disable and vector across mode combinations
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      {monitorMode, breakState, resetPinHighVolt, irqPinHighVolt} <= combos[i][4:1];
      repeat (3) @(negedge clk);
      check(watchdogDisable, 16'(combos[i][0]), "watchdog disable");
      check(resetVector, combos[i][4] ? 16'hFEFE : 16'hFFFE, "vector");
    end
    end_of_test();
  end
endmodule : reset_sequencer_and_prescaler_test
